// ===== hdl/blink_pkg.sv
`default_nettype none
package blink_pkg;

   // ==================================================
   // register map
   localparam logic [3:0] FEATURE_ADDR_LOW = 4'he;
   localparam logic [7:0] FEATURE_RESET    = 8'h00;
   localparam logic [7:0] SPARE_MASK       = 8'hf7;

   // ==================================================
   // field positions of the feature register
   localparam int EXT_CLOCK_POS   = 0;
   localparam int SOFT_RESET_POS  = 1;
   localparam int DECODER_POS     = 2;
   localparam int SPARE_POS       = 3;
   localparam int FLASH_EN_POS    = 4;
   localparam int PERIOD_POS      = 5;
   localparam int ALIGN_POS       = 6;
   localparam int INIT_PHASE_POS  = 7;

   typedef struct packed {
      logic flash_initial_phase;
      logic flash_align;
      logic flash_period_select;
      logic flash_enable;
      logic spare_bit;
      logic decoder_kind_select;
      logic soft_control_reset;
      logic ext_clock_select;
   } feature_t;

   // ==================================================
   // blink timing
   localparam longint CLOCK_HZ       = 100_000_000;
   localparam longint HALF_SHORT_MS  = 500;
   localparam longint HALF_LONG_MS   = 1000;
   localparam int unsigned HALF_SHORT_CYCLES =
      int'((CLOCK_HZ * HALF_SHORT_MS) / 1000);
   localparam int unsigned HALF_LONG_CYCLES =
      int'((CLOCK_HZ * HALF_LONG_MS) / 1000);

   // ==================================================
   // seven-segment font, bits a..g in 6..0
   function automatic logic [6:0] font7(input logic [3:0] code,
                                        input logic       hex);
      logic [6:0] seg;
      seg = 7'h00;
      unique case (code)
         4'h0: seg = 7'h7e;
         4'h1: seg = 7'h30;
         4'h2: seg = 7'h6d;
         4'h3: seg = 7'h79;
         4'h4: seg = 7'h33;
         4'h5: seg = 7'h5b;
         4'h6: seg = 7'h5f;
         4'h7: seg = 7'h70;
         4'h8: seg = 7'h7f;
         4'h9: seg = 7'h7b;
         4'ha: seg = hex ? 7'h77 : 7'h01;
         4'hb: seg = hex ? 7'h1f : 7'h4f;
         4'hc: seg = hex ? 7'h4e : 7'h37;
         4'hd: seg = hex ? 7'h3d : 7'h0e;
         4'he: seg = hex ? 7'h4f : 7'h67;
         4'hf: seg = hex ? 7'h47 : 7'h00;
      endcase
      return seg;
   endfunction

endpackage
`default_nettype wire

// ===== hdl/feature_control_blink.sv
`timescale 1ns/1ps
`default_nettype none
module feature_control_blink #(
   parameter int unsigned HALF_SHORT = blink_pkg::HALF_SHORT_CYCLES,
   parameter int unsigned HALF_LONG  = blink_pkg::HALF_LONG_CYCLES
) (
   // system
   input  wire logic       clock,
   input  wire logic       rst,
   // register write port from the serial front end (same clock)
   input  wire logic       reg_wr_en,
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wr_data,
   output logic      [7:0] reg_rd_data,
   // pins from outside the clock domain
   input  wire logic       serial_clock,
   input  wire logic       load_strobe,
   // display data path
   input  wire logic [7:0] digit_data,
   input  wire logic       digit_decode,
   output logic      [7:0] segment_out,
   output logic            display_lit,
   // steering of the rest of the device
   output logic            ext_clock_sel,
   output logic            control_reset,
   output logic            decode_hex
);

   // ==================================================
   // state
   blink_pkg::feature_t feature_reg;
   blink_pkg::feature_t feature_next;
   logic [31:0]         count_reg;
   logic [31:0]         count_next;
   logic                phase_reg;
   logic                phase_next;
   logic                sclk_meta_reg;
   logic                sclk_sync_reg;
   logic                sclk_prev_reg;
   logic                load_meta_reg;
   logic                load_sync_reg;
   logic                load_prev_reg;
   logic [7:0]          rd_data_reg;
   logic [7:0]          segment_reg;
   logic                lit_reg;
   logic                ext_sel_reg;
   logic                ctrl_reset_reg;
   logic                hex_reg;

   // ==================================================
   // register decode
   wire        feature_hit;
   wire [7:0]  wr_masked;

   // upper address nibble is a don't-care
   assign feature_hit = reg_wr_en &&
                        (reg_addr[3:0] == blink_pkg::FEATURE_ADDR_LOW);
   // spare bit never stored, so it always reads zero
   assign wr_masked   = reg_wr_data & blink_pkg::SPARE_MASK;
   assign feature_next = feature_hit ? blink_pkg::feature_t'(wr_masked)
                                     : feature_reg;

   // ==================================================
   // pin synchronisers and edge finders
   wire sclk_rise;
   wire load_rise;

   assign sclk_rise = sclk_sync_reg && !sclk_prev_reg;
   assign load_rise = load_sync_reg && !load_prev_reg;

   // first stage feeds only the second stage
   always_ff @(posedge clock) begin
      sclk_meta_reg <= serial_clock;
      sclk_sync_reg <= sclk_meta_reg;
      load_meta_reg <= load_strobe;
      load_sync_reg <= load_meta_reg;
   end

   // previous sampled levels, cleared in reset, so a pin held high through reset shows one rise right after it
   always_ff @(posedge clock) begin
      if (rst) begin
         sclk_prev_reg <= 1'b0;
         load_prev_reg <= 1'b0;
      end else begin
         sclk_prev_reg <= sclk_sync_reg;
         load_prev_reg <= load_sync_reg;
      end
   end

   // ==================================================
   // blink timebase
   wire        tick;
   wire        align_hit;
   wire [31:0] half_limit;
   wire        half_end;
   wire        flashing;

   // external mode advances once per serial clock rise
   assign tick       = feature_reg.ext_clock_select ? sclk_rise
                                                    : 1'b1;
   assign align_hit  = feature_reg.flash_align && load_rise;
   assign half_limit = feature_reg.flash_period_select
                       ? 32'(HALF_LONG) : 32'(HALF_SHORT);
   // >= keeps a period switch in mid-phase from running past the limit
   assign half_end   = tick && (count_reg >= half_limit - 32'h1);
   assign flashing   = feature_reg.flash_enable;

   // counter held at zero while blinking is off, so every start
   // opens with a full first phase
   always_comb begin
      count_next = count_reg + 32'h1;
      if (align_hit || !flashing) begin
         count_next = 32'h0;
      end else if (!tick) begin
         count_next = count_reg;
      end else if (half_end) begin
         count_next = 32'h0;
      end
   end

   // phase follows the start bit until blinking runs; it takes the
   // value being written, so the first phase obeys the new start bit
   always_comb begin
      phase_next = phase_reg;
      if (align_hit || !flashing) begin
         phase_next = feature_next.flash_initial_phase;
      end else if (half_end) begin
         phase_next = !phase_reg;
      end
   end

   // ==================================================
   // display path
   wire [6:0] font_seg;
   wire [7:0] shown;
   wire       lit_next;

   assign font_seg = blink_pkg::font7(digit_data[3:0],
                                      feature_reg.decoder_kind_select);
   assign shown    = digit_decode ? {digit_data[7], font_seg}
                                  : digit_data;
   // output trails the phase by one edge, so the edge on which blinking
   // starts still shows steady and every first phase is shown in full
   assign lit_next = !flashing || phase_reg;
   // blanking gates the outputs only; stored digit data stays put

   // ==================================================
   // registers
   always_ff @(posedge clock) begin
      if (rst) begin
         feature_reg <= blink_pkg::feature_t'(blink_pkg::FEATURE_RESET);
         count_reg   <= 32'h0;
         phase_reg   <= 1'b0;
      end else begin
         feature_reg <= feature_next;
         count_reg   <= count_next;
         phase_reg   <= phase_next;
      end
   end

   // registered outputs
   always_ff @(posedge clock) begin
      if (rst) begin
         rd_data_reg    <= 8'h00;
         segment_reg    <= 8'h00;
         lit_reg        <= 1'b0;
         ext_sel_reg    <= 1'b0;
         ctrl_reset_reg <= 1'b0;
         hex_reg        <= 1'b0;
      end else begin
         rd_data_reg    <= feature_next;
         segment_reg    <= lit_next ? shown : 8'h00;
         lit_reg        <= lit_next;
         ext_sel_reg    <= feature_next.ext_clock_select;
         ctrl_reset_reg <= feature_next.soft_control_reset;
         hex_reg        <= feature_next.decoder_kind_select;
      end
   end

   assign reg_rd_data   = rd_data_reg;
   assign segment_out   = segment_reg;
   assign display_lit   = lit_reg;
   assign ext_clock_sel = ext_sel_reg;
   assign control_reset = ctrl_reset_reg;
   assign decode_hex    = hex_reg;

   // ==================================================
   // assertions
   default clocking cb @(posedge clock); endclocking

   a_reset_clears: assert property (
      rst |=> (feature_reg == 8'h00) && (reg_rd_data == 8'h00))
      else $error("feature register not cleared by reset");

   a_write_decode: assert property (disable iff (rst)
      reg_wr_en && (reg_addr[3:0] == 4'he) |=>
         (reg_rd_data == (($past(reg_wr_data)) & 8'hf7)))
      else $error("write to feature address not stored");

   a_write_miss: assert property (disable iff (rst)
      reg_wr_en && (reg_addr[3:0] != 4'he) |=> $stable(feature_reg))
      else $error("write to other address changed feature register");

   a_ext_tick: assert property (disable iff (rst)
      feature_reg.ext_clock_select && flashing && !sclk_rise &&
      !align_hit |=> $stable(count_reg))
      else $error("counter moved without serial clock edge");

   a_soft_reset: assert property (disable iff (rst)
      reg_wr_en && (reg_addr[3:0] == 4'he) && reg_wr_data[1] |=>
         control_reset && (ext_clock_sel == $past(reg_wr_data[0])))
      else $error("soft reset not issued or feature lost");

   a_data_kept: assert property (disable iff (rst)
      feature_reg.soft_control_reset && lit_next |=>
         (segment_out == $past(shown)))
      else $error("digit data altered during soft reset");

   a_hex_font: assert property (disable iff (rst)
      feature_reg.decoder_kind_select && digit_decode &&
      (digit_data[3:0] == 4'ha) && lit_next |=>
         (segment_out[6:0] == 7'h77))
      else $error("hex font not applied");

   a_flash_off: assert property (disable iff (rst)
      !flashing ##1 !flashing |-> display_lit)
      else $error("display blanked while blinking off");

   a_half_toggle: assert property (disable iff (rst)
      flashing && half_end && !align_hit |=> phase_reg != $past(phase_reg))
      else $error("blink phase missed its toggle");

   a_count_bound: assert property (disable iff (rst)
      count_reg < half_limit || $changed(feature_reg))
      else $error("blink counter beyond half period");

   a_align_clear: assert property (disable iff (rst)
      align_hit |=> (count_reg == 32'h0) &&
         (phase_reg == $past(feature_next.flash_initial_phase)))
      else $error("load strobe edge did not clear timing");

   a_first_phase: assert property (disable iff (rst)
      !flashing |=> phase_reg == $past(feature_next.flash_initial_phase))
      else $error("first blink phase wrong");

   a_spare_zero: assert property (disable iff (rst)
      reg_rd_data[3] == 1'b0)
      else $error("spare bit reads nonzero");

   a_blank_off: assert property (disable iff (rst)
      !display_lit |-> (segment_out == 8'h00))
      else $error("segments driven during off phase");

   // reset leaves every output dark and every steering line neutral
   a_reset_outputs: assert property (
      rst |=> (segment_out == 8'h00) && !display_lit && !control_reset &&
         !ext_clock_sel && !decode_hex)
      else $error("outputs not cleared by reset");

   // steering lines are level copies of the stored bits
   a_ext_follow: assert property (disable iff (rst)
      ext_clock_sel == feature_reg.ext_clock_select)
      else $error("clock select output differs from register");

   a_ctrl_level: assert property (disable iff (rst)
      control_reset == feature_reg.soft_control_reset)
      else $error("control reset output differs from register");

   a_hex_steer: assert property (disable iff (rst)
      reg_wr_en && (reg_addr[3:0] == 4'he) |=>
         (decode_hex == $past(reg_wr_data[2])))
      else $error("decoder select not steered");

   // internal mode counts every system clock between phase ends
   a_int_tick: assert property (disable iff (rst)
      !feature_reg.ext_clock_select && flashing && !align_hit &&
      !half_end |=> (count_reg == $past(count_reg) + 32'h1))
      else $error("counter skipped a system clock");

   a_phase_hold: assert property (disable iff (rst)
      flashing && !half_end && !align_hit |=> $stable(phase_reg))
      else $error("blink phase moved inside a half period");

   // a strobe edge with the align bit clear must leave timing alone
   a_strobe_refused: assert property (disable iff (rst)
      flashing && !feature_reg.flash_align && load_rise && tick &&
      !half_end |=> (count_reg == $past(count_reg) + 32'h1))
      else $error("load strobe acted with align off");

   a_lit_trails: assert property (disable iff (rst)
      flashing |=> (display_lit == $past(phase_reg)))
      else $error("display does not follow blink phase");

   c_blink_toggle: cover property (disable iff (rst)
      flashing && half_end);
   c_align_edge: cover property (disable iff (rst)
      align_hit && flashing);
   c_ext_tick: cover property (disable iff (rst)
      feature_reg.ext_clock_select && sclk_rise && flashing);
   c_lit_start: cover property (disable iff (rst)
      !flashing ##1 (flashing && phase_reg));
   c_strobe_refused: cover property (disable iff (rst)
      flashing && !feature_reg.flash_align && load_rise);

endmodule
`default_nettype wire

// ===== testbench/host_pins.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// host side pins: link clock and load strobe
module host_pins (
   // control from the bench
   input  wire logic run_clk,
   input  wire logic strobe_req,
   // pins toward the block
   output var  logic serial_clock,
   output var  logic load_strobe
);
   // link clock stands low between frames, 80 ns period within them;
   // the 3 ns offset plus 37 ns puts its edges on falling system clock edges, clear of the rising ones
   initial begin
      serial_clock = 1'b0;
      forever begin
         #3;
         if (run_clk) begin
            #37 serial_clock = 1'b1;
            #40 serial_clock = 1'b0;
         end else begin
            #7;
         end
      end
   end

   // strobe pin follows the request directly
   always_comb load_strobe = strobe_req;
endmodule
`default_nettype wire

// ===== testbench/feature_control_blink_tb.sv
`timescale 1ns/1ps
`default_nettype none
module feature_control_blink_tb;
   // ==========================================
   // short half periods keep the run brief
   localparam int HS = 4;
   localparam int HL = 8;
   logic       clock = 1'b0;
   logic       rst = 1'b1;
   logic       reg_wr_en = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wr_data = 8'h00;
   logic [7:0] digit_data = 8'h00;
   logic       digit_decode = 1'b0;
   logic       run_clk = 1'b0;
   logic       strobe_req = 1'b0;
   logic       serial_clock, load_strobe, display_lit;
   logic       ext_clock_sel, control_reset, decode_hex;
   logic [7:0] reg_rd_data, segment_out;
   int         miscompares = 0;
   int         cmp_count = 0;

   feature_control_blink #(.HALF_SHORT(HS), .HALF_LONG(HL)) dut_u (
      .clock(clock), .rst(rst), .reg_wr_en(reg_wr_en),
      .reg_addr(reg_addr), .reg_wr_data(reg_wr_data),
      .reg_rd_data(reg_rd_data), .serial_clock(serial_clock),
      .load_strobe(load_strobe), .digit_data(digit_data),
      .digit_decode(digit_decode), .segment_out(segment_out),
      .display_lit(display_lit), .ext_clock_sel(ext_clock_sel),
      .control_reset(control_reset), .decode_hex(decode_hex));

   host_pins host_u (.run_clk(run_clk), .strobe_req(strobe_req),
      .serial_clock(serial_clock), .load_strobe(load_strobe));

   // ==========================================
   // clock and watchdog
   initial begin
      forever #5 clock = ~clock;
   end
   initial begin
      #500us;
      miscompares++;
      end_sim();
   end

   // ==========================================
   // shared tasks
   task automatic end_sim();
      $display("miscompares %0d cmp_count %0d", miscompares, cmp_count);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, exp, input string msg);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR %0t: %s got %h exp %h", $time, msg, got, exp);
      end
   endtask

   // write lands on the next edge; returns where the new value shows
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      reg_wr_en   <= 1'b1;
      reg_addr    <= a;
      reg_wr_data <= d;
      @(posedge clock);
      reg_wr_en   <= 1'b0;
      @(negedge clock);
   endtask

   task automatic wait_lit(input logic v);
      for (int i = 0; i < 300 && display_lit !== v; i++) @(negedge clock);
   endtask

   // length of a run of display_lit at level v, capped at 300
   task automatic run_len(input logic v, output int n);
      n = 0;
      wait_lit(v);
      while (display_lit === v && n < 300) begin
         n++;
         @(negedge clock);
      end
   endtask

   // three reset edges at the start, two in mid-run
   task automatic rst_chk();
      @(posedge clock);
      rst <= 1'b1;
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      @(negedge clock);
      chk(reg_rd_data, 8'h00, "reset value");
      chk({5'h0, ext_clock_sel, control_reset, decode_hex}, 8'h00,
          "reset steering");
      chk(segment_out, 8'h00, "blank in reset");
      chk({7'h0, display_lit}, 8'h00, "dark in reset");
      @(negedge clock);
      chk({7'h0, display_lit}, 8'h01, "lit after reset");
   endtask

   // ==========================================
   // scenarios
   task automatic regs();
      wr(8'h3e, 8'hff);
      chk(reg_rd_data, 8'hf7, "upper nibble ignored, spare dropped");
      chk({5'h0, ext_clock_sel, control_reset, decode_hex}, 8'h07,
          "steering on");
      wr(8'h0d, 8'h00);
      chk(reg_rd_data, 8'hf7, "other address");
      rst_chk();
   endtask

   task automatic decode();
      @(posedge clock);
      digit_data   <= 8'h8a;
      digit_decode <= 1'b1;
      wr(8'h0e, 8'h00);
      @(negedge clock);
      chk(segment_out, 8'h81, "code-B digit");
      wr(8'h0e, 8'h04);
      @(negedge clock);
      chk(segment_out, 8'hf7, "hex digit");
      wr(8'h0e, 8'h06);
      @(negedge clock);
      chk(segment_out, 8'hf7, "digits kept in soft reset");
      chk({7'h0, control_reset}, 8'h01, "soft reset level");
      @(posedge clock);
      digit_decode <= 1'b0;
      digit_data   <= 8'h5a;
      repeat (2) @(negedge clock);
      chk(segment_out, 8'h5a, "raw digit");
   endtask

   task automatic blink(input logic [7:0] d, input int h);
      int n;
      wr(8'h0e, 8'h00);
      wr(8'h0e, d);
      @(negedge clock);
      chk({7'h0, display_lit}, {7'h0, d[7]}, "first phase");
      run_len(d[7], n);
      chk(8'(n), 8'(h), "first half period");
      run_len(!d[7], n);
      chk(8'(n), 8'(h), "second half period");
      wait_lit(1'b0);
      chk(segment_out, 8'h00, "blanked phase");
   endtask

   // strobe one cycle into the lit phase of the long period
   task automatic align(input logic [7:0] d, input logic cut);
      int n;
      wr(8'h0e, 8'h00);
      wr(8'h0e, d);
      wait_lit(1'b0);
      wait_lit(1'b1);
      @(posedge clock);
      strobe_req <= 1'b1;
      @(negedge clock);
      run_len(1'b1, n);
      chk({7'h0, n < HL - 1}, {7'h0, cut}, "strobe restart");
      run_len(1'b0, n);
      chk(8'(n), 8'(HL), "low after strobe");
      @(posedge clock);
      strobe_req <= 1'b0;
   endtask

   // ticks come only from the link clock: still link, frozen phase
   task automatic ext_clk();
      int n;
      wr(8'h0e, 8'h00);
      wr(8'h0e, 8'h11);
      run_len(1'b0, n);
      chk(8'(n), 8'd44, "frozen without link clock");
      @(posedge clock);
      run_clk <= 1'b1;
      run_len(1'b1, n);
      chk(8'(n), 8'(HS * 8), "half period in link ticks");
      @(posedge clock);
      run_clk <= 1'b0;
      wr(8'h0e, 8'h00);
      @(negedge clock);
      run_len(1'b1, n);
      chk(8'(n), 8'd44, "steady lit with blink off");
   endtask

   // ==========================================
   // main sequence
   initial begin
      rst_chk();
      regs();
      decode();
      blink(8'h10, HS);
      blink(8'h90, HS);
      blink(8'h30, HL);
      blink(8'hb0, HL);
      align(8'h70, 1'b1);
      align(8'h30, 1'b0);
      ext_clk();
      wr(8'h0e, 8'hff);
      rst_chk();
      end_sim();
   end
endmodule
`default_nettype wire
